// File: rtl/rog_delay.sv
`default_nettype none
module rog_delay
  import rog_pkg::*;
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Delay request and result
  rog_dly_if.dly    d
);
  logic        out_reg;
  logic        out_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] target;

  always_comb
  begin
    target   = d.din ? d.on_ms : d.off_ms;
    out_next = out_reg;
    cnt_next = cnt_reg;
    if (!d.en || d.din == out_reg)
    begin
      // Pending change withdrawn: restart the wait next time
      out_next = d.din;
      cnt_next = 16'h0000;
    end
    else if (cnt_reg >= target)
    begin
      out_next = d.din;
      cnt_next = 16'h0000;
    end
    else if (d.tick)
    begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_reg <= 1'b0;
      cnt_reg <= 16'h0000;
    end
    else
    begin
      out_reg <= out_next;
      cnt_reg <= cnt_next;
    end
  end

  // Bypass when disabled, so no extra pipeline stage sits in the plain path
  assign d.dout = d.en ? out_reg : d.din;
endmodule : rog_delay
`default_nettype wire

// File: rtl/rog_dly_if.sv
`default_nettype none
interface rog_dly_if;
  logic        tick;
  logic        en;
  logic [15:0] on_ms;
  logic [15:0] off_ms;
  logic        din;
  logic        dout;
  modport ctl (output tick, output en, output on_ms, output off_ms, output din, input dout);
  modport dly (input tick, input en, input on_ms, input off_ms, input din, output dout);
endinterface : rog_dly_if
`default_nettype wire

// File: rtl/rog_ms_tick.sv
`default_nettype none
module rog_ms_tick
  import rog_pkg::*;
#(
  parameter int unsigned CYCLES = MS_CYCLES
)(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Millisecond pulse
  output logic      tick
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg + 32'h0000_0001;
    if (cnt_reg >= 32'(CYCLES - 1))
    begin
      cnt_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = (cnt_reg >= 32'(CYCLES - 1));
endmodule : rog_ms_tick
`default_nettype wire

// File: rtl/rog_pkg.sv
`default_nettype none
package rog_pkg;
  // Clock and millisecond base
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [11:0] OFS_CONFIG = 12'h000;
  localparam logic [11:0] OFS_BLINK  = 12'h004;
  localparam logic [11:0] OFS_DELAY  = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;

  // Config fields
  localparam int unsigned CFG_TYPE_LSB    = 0;
  localparam int unsigned CFG_GATE_LSB    = 4;
  localparam int unsigned CFG_OVR_POL     = 8;
  localparam int unsigned CFG_OVR_STATE   = 9;
  localparam int unsigned CFG_UNL_PERMIT  = 10;
  localparam int unsigned CFG_DLY_EN      = 11;
  localparam int unsigned CFG_GATE_USED   = 12;
  localparam int unsigned CFG_OVR_USED    = 13;
  localparam logic [31:0] CFG_WMASK       = 32'h0000_3f77;
  localparam logic [31:0] CFG_RESET       = 32'h0000_0001;

  // Response styles
  localparam logic [2:0] TYPE_UNUSED   = 3'h0;
  localparam logic [2:0] TYPE_NORMAL   = 3'h1;
  localparam logic [2:0] TYPE_INVERSE  = 3'h2;
  localparam logic [2:0] TYPE_LATCHED  = 3'h3;
  localparam logic [2:0] TYPE_INV_LAT  = 3'h4;
  localparam logic [2:0] TYPE_TOGGLE   = 3'h5;

  // Gating responses
  localparam logic [2:0] GATE_EN_ON       = 3'h0;
  localparam logic [2:0] GATE_EN_OFF      = 3'h1;
  localparam logic [2:0] GATE_DIS_ON      = 3'h2;
  localparam logic [2:0] GATE_DIS_OFF     = 3'h3;
  localparam logic [2:0] GATE_EN_ON_HOLD  = 3'h4;
  localparam logic [2:0] GATE_EN_OFF_HOLD = 3'h5;

  // Timing setpoints in milliseconds
  localparam logic [15:0] BLINK_MS_RESET = 16'h01f4;
  localparam logic [31:0] DELAY_RESET    = 32'h0000_0000;
endpackage : rog_pkg
`default_nettype wire

// File: rtl/rog_relay.sv
// How it works
// - Gating response setting takes six codes, zero to five.
// - Codes 0 and 3 follow control while gate on, else off.
// - Codes 1 and 2 follow control while gate off, else off.
// - Code 4 follows control while gate on, else holds last state.
// - Code 5 follows control while gate off, else holds last state.
// - Active override beats gating entirely.
// - Override polarity 0 acts on signal off, 1 on signal on.
// - Forced state 0 selects normally open, 1 normally closed.
// - Unlatch works only in latched styles with unlatch permitted.
// - Latched style: unlatch on forces off, stays off after release.
// - Inverse latched style: unlatch on forces on, stays on after.
// - Latched toggles on control rising edge; inverse latched on falling.
// - Inverse style: control on gives normally open, off normally closed.
// - Toggle style alternates once per blink interval, default 500 ms.
// - With delay enabled, wait on-delay or off-delay in ms before change.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`default_nettype none
module rog_relay
  import rog_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
)(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Selected on/off sources
  input  wire logic        ctrl_in,
  input  wire logic        gate_in,
  input  wire logic        override_in,
  input  wire logic        unlatch_in,
  // Relay contact select
  output logic             relay_nc,
  output logic             relay_no
);
  ////////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic [15:0] blink_ms_reg;
  logic [15:0] blink_ms_next;
  logic [31:0] delay_reg;
  logic [31:0] delay_next;
  logic [11:0] addr_reg;
  logic [11:0] addr_next;
  logic        wr_reg;
  logic        wr_next;
  logic [31:0] status;

  // Registered control state
  logic        relay_reg;
  logic        relay_next;
  logic        latch_reg;
  logic        latch_next;
  logic        ctrl_prev_reg;
  logic        ctrl_prev_next;
  logic        blink_reg;
  logic        blink_next;
  logic [15:0] blink_cnt_reg;
  logic [15:0] blink_cnt_next;

  // Decoded settings and combinational terms
  logic [2:0]  out_type;
  logic [2:0]  gate_resp;
  logic        ovr_active;
  logic        unl_effective;
  logic        style_out;
  logic        delayed_out;
  logic        gated_out;
  logic        ms_tick;

  always_comb
  begin
    cfg_next      = cfg_reg;
    blink_ms_next = blink_ms_reg;
    delay_next    = delay_reg;
    addr_next     = addr_reg;
    wr_next       = 1'b0;
    // Data phase of a write accepted last cycle
    if (wr_reg)
    begin
      if (addr_reg == OFS_CONFIG)
      begin
        cfg_next = hwdata & CFG_WMASK;
      end
      else if (addr_reg == OFS_BLINK)
      begin
        blink_ms_next = hwdata[15:0];
      end
      else if (addr_reg == OFS_DELAY)
      begin
        delay_next = hwdata;
      end
    end
    if (hsel && hready && htrans[1])
    begin
      addr_next = {haddr[11:2], 2'b00};
      wr_next   = hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_reg      <= CFG_RESET;
      blink_ms_reg <= BLINK_MS_RESET;
      delay_reg    <= DELAY_RESET;
      addr_reg     <= 12'h000;
      wr_reg       <= 1'b0;
    end
    else
    begin
      cfg_reg      <= cfg_next;
      blink_ms_reg <= blink_ms_next;
      delay_reg    <= delay_next;
      addr_reg     <= addr_next;
      wr_reg       <= wr_next;
    end
  end

  assign status = {24'h00_0000, style_out, ovr_active, latch_reg, unlatch_in,
                   override_in, gate_in, ctrl_in, relay_reg};

  // Read mux over flops and live status bits; unmapped offsets read zero
  always_comb
  begin
    if (addr_reg == OFS_CONFIG)
    begin
      hrdata = cfg_reg;
    end
    else if (addr_reg == OFS_BLINK)
    begin
      hrdata = {16'h0000, blink_ms_reg};
    end
    else if (addr_reg == OFS_DELAY)
    begin
      hrdata = delay_reg;
    end
    else if (addr_reg == OFS_STATUS)
    begin
      hrdata = status;
    end
    else
    begin
      hrdata = 32'h0000_0000;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond base and response delay
  rog_ms_tick #(
    .CYCLES  (MS_CYC)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (ms_tick)
  );

  rog_dly_if dly_bus ();

  assign dly_bus.tick   = ms_tick;
  assign dly_bus.en     = cfg_reg[CFG_DLY_EN];
  assign dly_bus.on_ms  = delay_reg[15:0];
  assign dly_bus.off_ms = delay_reg[31:16];
  assign dly_bus.din    = style_out;
  assign delayed_out    = dly_bus.dout;

  rog_delay u_delay (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (dly_bus.dly)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Response style
  assign out_type      = cfg_reg[CFG_TYPE_LSB +: 3];
  assign gate_resp     = cfg_reg[CFG_GATE_LSB +: 3];
  assign unl_effective = unlatch_in && cfg_reg[CFG_UNL_PERMIT]
                         && (out_type == TYPE_LATCHED || out_type == TYPE_INV_LAT);

  always_comb
  begin
    latch_next     = latch_reg;
    ctrl_prev_next = ctrl_in;
    blink_next     = blink_reg;
    blink_cnt_next = blink_cnt_reg;
    if (unl_effective)
    begin
      // Held while unlatch is on; edges of control are ignored meanwhile
      latch_next = (out_type == TYPE_INV_LAT);
    end
    else if (out_type == TYPE_LATCHED && ctrl_in && !ctrl_prev_reg)
    begin
      latch_next = !latch_reg;
    end
    else if (out_type == TYPE_INV_LAT && !ctrl_in && ctrl_prev_reg)
    begin
      latch_next = !latch_reg;
    end
    // Blink runs only while control is on, so a stopped blinker is off
    if (out_type != TYPE_TOGGLE || !ctrl_in)
    begin
      blink_next     = 1'b0;
      blink_cnt_next = 16'h0000;
    end
    else if (ms_tick)
    begin
      if (blink_cnt_reg + 16'h0001 >= blink_ms_reg)
      begin
        blink_next     = !blink_reg;
        blink_cnt_next = 16'h0000;
      end
      else
      begin
        blink_cnt_next = blink_cnt_reg + 16'h0001;
      end
    end
    case (out_type)
      TYPE_NORMAL:  style_out = ctrl_in;
      TYPE_INVERSE: style_out = !ctrl_in;
      TYPE_LATCHED: style_out = latch_reg;
      TYPE_INV_LAT: style_out = latch_reg;
      TYPE_TOGGLE:  style_out = blink_reg;
      default:      style_out = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Gating and override
  always_comb
  begin
    if (!cfg_reg[CFG_GATE_USED])
    begin
      gated_out = delayed_out;
    end
    else
    begin
      case (gate_resp)
        GATE_EN_ON, GATE_DIS_OFF:  gated_out = gate_in && delayed_out;
        GATE_EN_OFF, GATE_DIS_ON:  gated_out = !gate_in && delayed_out;
        GATE_EN_ON_HOLD:  gated_out = gate_in ? delayed_out : relay_reg;
        GATE_EN_OFF_HOLD: gated_out = gate_in ? relay_reg : delayed_out;
        default:          gated_out = 1'b0;
      endcase
    end
  end

  assign ovr_active = cfg_reg[CFG_OVR_USED]
                      && (cfg_reg[CFG_OVR_POL] ? override_in : !override_in);

  always_comb
  begin
    if (out_type == TYPE_UNUSED)
    begin
      relay_next = 1'b0;
    end
    else if (ovr_active)
    begin
      relay_next = cfg_reg[CFG_OVR_STATE];
    end
    else
    begin
      relay_next = gated_out;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      relay_reg     <= 1'b0;
      latch_reg     <= 1'b0;
      ctrl_prev_reg <= 1'b0;
      blink_reg     <= 1'b0;
      blink_cnt_reg <= 16'h0000;
    end
    else
    begin
      relay_reg     <= relay_next;
      latch_reg     <= latch_next;
      ctrl_prev_reg <= ctrl_prev_next;
      blink_reg     <= blink_next;
      blink_cnt_reg <= blink_cnt_next;
    end
  end

  // Relay on means common rests on normally closed
  assign relay_nc = relay_reg;
  assign relay_no = !relay_reg;
endmodule : rog_relay
`default_nettype wire

// File: testbench/rog_relay_sva.sv
`default_nettype none
module rog_relay_sva
  import rog_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
)(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // Sources and relay
  input wire logic        ctrl_in,
  input wire logic        gate_in,
  input wire logic        override_in,
  input wire logic        unlatch_in,
  input wire logic        relay_nc,
  input wire logic        relay_no
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // Config shadow, written on the same edge as the real register
  logic        wr_reg;
  logic        wr_next;
  logic [9:0]  idx_reg;
  logic [9:0]  idx_next;
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  always_comb
  begin
    wr_next  = hsel && hready && htrans[1] && hwrite;
    idx_next = (hsel && hready && htrans[1]) ? haddr[11:2] : idx_reg;
    cfg_next = cfg_reg;
    if (wr_reg && idx_reg == OFS_CONFIG[11:2])
    begin
      cfg_next = hwdata & CFG_WMASK;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_reg  <= 1'b0;
      idx_reg <= 10'h000;
      cfg_reg <= CFG_RESET;
    end
    else
    begin
      wr_reg  <= wr_next;
      idx_reg <= idx_next;
      cfg_reg <= cfg_next;
    end
  end
  wire logic [2:0] style = cfg_reg[2:0];
  wire logic [2:0] gcode = cfg_reg[6:4];
  wire logic       is_inv = style == TYPE_INVERSE;
  wire logic       ovr_act = cfg_reg[CFG_OVR_USED] && (override_in == cfg_reg[CFG_OVR_POL]);
  wire logic       gate_off = cfg_reg[CFG_GATE_USED]
    && (((gcode == GATE_EN_ON || gcode == GATE_DIS_OFF) && !gate_in)
    || ((gcode == GATE_EN_OFF || gcode == GATE_DIS_ON) && gate_in));
  wire logic       gate_hold = cfg_reg[CFG_GATE_USED]
    && ((gcode == GATE_EN_ON_HOLD && !gate_in) || (gcode == GATE_EN_OFF_HOLD && gate_in));
  // Delay and unused style are left out: their timing is not a one-edge relation
  wire logic       plain = !cfg_reg[CFG_DLY_EN] && !ovr_act && style != TYPE_UNUSED;
  wire logic       open = plain && !gate_off && !gate_hold;
  ////////////////////////////////////////
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_contacts;
    relay_no == !relay_nc;
  endproperty
  a_contacts: assert property (p_contacts) else $error("contacts not complementary");
  property p_rst;
    !$past(hresetn) |-> !relay_nc;
  endproperty
  a_rst: assert property (p_rst) else $error("relay not off after reset");
  property p_ovr;
    ovr_act && !cfg_reg[CFG_DLY_EN] && style != TYPE_UNUSED
      |=> relay_nc == $past(cfg_reg[CFG_OVR_STATE]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override state not applied");
  property p_gate_off;
    plain && gate_off |=> !relay_nc;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gated relay not off");
  property p_follow;
    open && (style == TYPE_NORMAL || is_inv) |=> relay_nc == ($past(ctrl_in) != $past(is_inv));
  endproperty
  a_follow: assert property (p_follow) else $error("relay not following control");
  property p_hold;
    plain && gate_hold |=> $stable(relay_nc);
  endproperty
  a_hold: assert property (p_hold) else $error("relay changed while held");
  property p_latch;
    open && !unlatch_in && ((style == TYPE_LATCHED && $rose(ctrl_in))
      || (style == TYPE_INV_LAT && $fell(ctrl_in))) |-> ##2 relay_nc != $past(relay_nc);
  endproperty
  a_latch: assert property (p_latch) else $error("latch did not toggle");
  property p_unl_off;
    (style == TYPE_LATCHED && cfg_reg[CFG_UNL_PERMIT] && unlatch_in && open)[*2] |=> !relay_nc;
  endproperty
  a_unl_off: assert property (p_unl_off) else $error("unlatch did not force off");
  property p_unl_on;
    (style == TYPE_INV_LAT && cfg_reg[CFG_UNL_PERMIT] && unlatch_in && open)[*2] |=> relay_nc;
  endproperty
  a_unl_on: assert property (p_unl_on) else $error("unlatch did not force on");
endmodule : rog_relay_sva
bind rog_relay rog_relay_sva #(.MS_CYC(MS_CYC)) rog_relay_sva_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .ctrl_in(ctrl_in), .gate_in(gate_in),
  .override_in(override_in), .unlatch_in(unlatch_in), .relay_nc(relay_nc), .relay_no(relay_no)
);
`default_nettype wire

// File: testbench/rog_src_model.sv
`default_nettype none
module rog_src_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Wanted levels: ctrl, gate, override, unlatch
  input  wire logic [3:0] want,
  // On/off sources
  output logic            ctrl_in,
  output logic            gate_in,
  output logic            override_in,
  output logic            unlatch_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Source blocks are registered, so levels arrive one edge late
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {ctrl_in, gate_in, override_in, unlatch_in} <= 4'h0;
    end
    else
    begin
      {ctrl_in, gate_in, override_in, unlatch_in} <= want;
    end
  end
endmodule : rog_src_model
`default_nettype wire

// File: testbench/tb.sv
`default_nettype none
module tb
  import rog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MS_SIM = 4;
  typedef struct packed
  {
    logic [15:0] cfg;
    logic [3:0]  src;
    logic        exp;
  } rog_row_t;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  src_want;
  logic        ctrl_in;
  logic        gate_in;
  logic        override_in;
  logic        unlatch_in;
  logic        relay_nc;
  logic        relay_no;
  logic [31:0] q;
  logic        prev;
  int          n;
  int          error_cnt;
  int          total_checks;
  // Source order in src: ctrl, gate, override, unlatch
  rog_row_t rows [34] = '{
    '{16'h0001, 4'b1000, 1'b1}, '{16'h0001, 4'b0000, 1'b0}, '{16'h0000, 4'b1000, 1'b0},
    '{16'h0002, 4'b1000, 1'b0}, '{16'h0002, 4'b0000, 1'b1},
    '{16'h1001, 4'b1100, 1'b1}, '{16'h1001, 4'b1000, 1'b0},
    '{16'h1031, 4'b1100, 1'b1}, '{16'h1031, 4'b1000, 1'b0},
    '{16'h1011, 4'b1000, 1'b1}, '{16'h1011, 4'b1100, 1'b0},
    '{16'h1021, 4'b1000, 1'b1}, '{16'h1021, 4'b1100, 1'b0},
    '{16'h1041, 4'b1100, 1'b1}, '{16'h1041, 4'b0000, 1'b1},
    '{16'h1051, 4'b0000, 1'b0}, '{16'h1051, 4'b1100, 1'b0},
    '{16'h2201, 4'b0000, 1'b1}, '{16'h2301, 4'b0010, 1'b1},
    '{16'h2101, 4'b1010, 1'b0}, '{16'h2301, 4'b0000, 1'b0},
    '{16'h3301, 4'b0010, 1'b1}, '{16'h3101, 4'b1110, 1'b0},
    '{16'h0403, 4'b0001, 1'b0}, '{16'h0403, 4'b0000, 1'b0},
    '{16'h0403, 4'b1000, 1'b1}, '{16'h0403, 4'b0000, 1'b1},
    '{16'h0403, 4'b1000, 1'b0}, '{16'h0403, 4'b0000, 1'b0},
    '{16'h0403, 4'b1000, 1'b1}, '{16'h0003, 4'b1001, 1'b1},
    '{16'h0404, 4'b1001, 1'b1}, '{16'h0404, 4'b1000, 1'b1},
    '{16'h0404, 4'b0000, 1'b0}
  };
  rog_relay #(.MS_CYC(MS_SIM)) rog_relay_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ctrl_in(ctrl_in), .gate_in(gate_in),
    .override_in(override_in), .unlatch_in(unlatch_in), .relay_nc(relay_nc), .relay_no(relay_no)
  );
  rog_src_model rog_src_model_i (
    .hclk(hclk), .hresetn(hresetn), .want(src_want), .ctrl_in(ctrl_in), .gate_in(gate_in),
    .override_in(override_in), .unlatch_in(unlatch_in)
  );
  ////////////////////////////////////////
  task automatic test_done;
    $display("Checks: %0d, errors: %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wait_rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  // Settle time covers the source register lag plus the decision edge
  task automatic apply(input logic [3:0] s, input int cyc, input logic e, input string what);
    @(posedge hclk);
    src_want <= s;
    repeat (cyc) @(posedge hclk);
    chk({31'h0000_0000, relay_nc}, {31'h0000_0000, e}, what);
  endtask : apply
  ////////////////////////////////////////
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial
  begin
    repeat (5000) @(posedge hclk);
    error_cnt++;
    $display("Error at %0t ns: watchdog expired", $time);
    test_done();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    src_want = 4'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
    begin
      bus(1'b1, OFS_CONFIG, {16'h0000, rows[i].cfg}, q);
      apply(rows[i].src, 5, rows[i].exp, $sformatf("row %0d", i));
    end
    bus(1'b1, OFS_BLINK, 32'h0000_0002, q);
    bus(1'b1, OFS_CONFIG, 32'h0000_0005, q);
    @(posedge hclk);
    src_want <= 4'b1000;
    repeat (20) @(posedge hclk);
    chk({31'h0000_0000, relay_no}, {31'h0000_0000, !relay_nc}, "contacts complementary");
    n = 0;
    prev = relay_nc;
    repeat (160)
    begin
      @(posedge hclk);
      if (relay_nc !== prev)
        n++;
      prev = relay_nc;
    end
    chk(n, 32'h0000_0014, "blink changes in 160 cycles");
    bus(1'b1, OFS_DELAY, 32'h0002_0003, q);
    bus(1'b1, OFS_CONFIG, 32'h0000_0801, q);
    apply(4'b0000, 30, 1'b0, "delay idle");
    apply(4'b1000, 6, 1'b0, "on delay running");
    apply(4'b1000, 24, 1'b1, "on delay done");
    apply(4'b0000, 3, 1'b1, "off delay running");
    apply(4'b0000, 20, 1'b0, "off delay done");
    bus(1'b1, OFS_CONFIG, 32'h0000_0001, q);
    apply(4'b1000, 5, 1'b1, "on before reset");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({31'h0000_0000, relay_nc}, 32'h0000_0000, "relay in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0000_0000, relay_nc}, 32'h0000_0000, "relay after reset");
    bus(1'b0, OFS_CONFIG, 32'h0000_0000, q);
    chk(q, CFG_RESET, "config reset");
    bus(1'b0, OFS_BLINK, 32'h0000_0000, q);
    chk(q, {16'h0000, BLINK_MS_RESET}, "blink reset");
    bus(1'b0, OFS_DELAY, 32'h0000_0000, q);
    chk(q, DELAY_RESET, "delay reset");
    bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
    chk(q, 32'h0000_0083, "status after reset");
    bus(1'b1, OFS_CONFIG, 32'hffff_ffff, q);
    bus(1'b0, OFS_CONFIG, 32'h0000_0000, q);
    chk(q, CFG_WMASK, "config mask");
    bus(1'b1, 12'h100, 32'h1234_5678, q);
    bus(1'b0, 12'h100, 32'h0000_0000, q);
    chk(q, 32'h0000_0000, "unmapped read");
    test_done();
  end
endmodule : tb
`default_nettype wire
